// *** hdl/servo_status_outputs.sv ***
// Fault, warning and rotation-detect outputs plus origin offset.
// Assumes fault and warning conditions and motor speed come from
// logic on the same clock; commands are one-cycle pulses.
`timescale 1ns/1ps
module servo_status_outputs
(
   input  wire logic                      sys_clk_in,    // 125 MHz clock
   input  wire logic                      nrst_in,       // Sync reset, active low
   input  wire status_out_pkg::link_cmd_t cmd_in,        // Link command pulses
   input  wire logic                      fault_cond_in, // Error detected
   input  wire logic                      warn_cond_in,  // Warning present
   input  wire logic [15:0]               speed_in,      // |speed| in rpm
   input  wire logic [13:0]               level_in,      // Rotation level setting
   input  wire logic signed [31:0]        offset_in,     // Origin offset setting
   input  wire logic signed [31:0]        enc_pos_in,    // Encoder position
   output status_out_pkg::status_pins_t   pins_out,      // Discrete outputs
   output logic                           offset_on_out, // Offset in effect
   output logic signed [31:0]             mach_pos_out   // Machine position
);
   import status_out_pkg::*;

   typedef struct packed {
      logic               fault_latch;
      logic               pwr_seen;
      logic signed [31:0] offset_eff;
      status_pins_t       pins;
   } sso_state_t;

   sso_state_t         st_q;
   sso_state_t         st_d;
   logic [13:0]        level_c;
   logic signed [31:0] offset_c;

   // =====================================================
   // Setting clamps
   // =====================================================
   // Out-of-range settings saturate to the legal span
   always_comb
   begin
      if (level_in < LEVEL_MIN)
         level_c = LEVEL_MIN; // R8
      else if (level_in > LEVEL_MAX)
         level_c = LEVEL_MAX; // R8
      else
         level_c = level_in;
      if (offset_in > OFFSET_MAX)
         offset_c = OFFSET_MAX; // R3
      else if (offset_in < OFFSET_MIN)
         offset_c = OFFSET_MIN; // R3
      else
         offset_c = offset_in;
   end

   // =====================================================
   // Next-state logic
   // =====================================================
   // Fault set wins over a same-cycle clear; outputs follow next cycle
   always_comb
   begin
      st_d = st_q;
      if (cmd_in.encoder_power_on_cmd)
         st_d.pwr_seen = 1'b1; // R2
      if (fault_cond_in)
         st_d.fault_latch = 1'b1;
      else if (cmd_in.fault_clear_cmd)
         st_d.fault_latch = 1'b0; // R5
      // Offset tracks the setting at once, but only after power-on
      st_d.offset_eff = (st_q.pwr_seen || cmd_in.encoder_power_on_cmd)
                        ? offset_c : OFFSET_RESET; // R2 R3
      st_d.pins.fault_output = ~(st_q.fault_latch | fault_cond_in); // R4 R9
      st_d.pins.warn_output  = warn_cond_in; // R6 R9
      st_d.pins.rotation_detect_output = (speed_in >= {2'h0, level_c}); // R7 R8 R9
   end

   // State register
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         st_q.fault_latch <= 1'b0;
         st_q.pwr_seen    <= 1'b0;
         st_q.offset_eff  <= OFFSET_RESET;
         st_q.pins        <= PINS_RESET; // Fault output closed, others open
      end
      else
         st_q <= st_d;
   end

   // =====================================================
   // Outputs
   // =====================================================
   assign pins_out      = st_q.pins;
   assign offset_on_out = st_q.pwr_seen;

   // Machine coordinate stage
   offset_adder u_adder
   (
      .sys_clk_in   (sys_clk_in),
      .nrst_in      (nrst_in),
      .enc_pos_in   (enc_pos_in),
      .offset_in    (st_q.offset_eff),
      .mach_pos_out (mach_pos_out)
   );

   // =====================================================
   // Checks
   // =====================================================
   // A detected error opens the fault output one cycle later
   fault_open_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R4 R9
      fault_cond_in |=> !pins_out.fault_output)
      else $error("fault output stayed closed on error");

   // A held latch keeps the fault output open
   fault_latch_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R4
      st_q.fault_latch |=> !pins_out.fault_output)
      else $error("fault output closed while latch set");

   // No error and no latch gives a closed fault output
   fault_closed_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R4
      (!fault_cond_in && !st_q.fault_latch) |=> pins_out.fault_output)
      else $error("fault output open in normal status");

   // An error always lands in the latch, even beside a clear
   fault_set_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R5
      fault_cond_in |=> st_q.fault_latch)
      else $error("fault latch missed an error");

   // Without a clear the latched fault stays open
   fault_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R5
      fault_cond_in ##1 (!fault_cond_in && !cmd_in.fault_clear_cmd)
      |=> !pins_out.fault_output)
      else $error("fault released without clear command");

   // A clear with the cause gone closes the output again
   fault_clear_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R5
      (cmd_in.fault_clear_cmd && !fault_cond_in) ##1 !fault_cond_in
      |=> pins_out.fault_output)
      else $error("fault not cleared by command");

   // Warning output copies the condition one cycle later
   warn_follow_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R6 R9
      ##1 pins_out.warn_output == $past(warn_cond_in))
      else $error("warning output wrong");

   // In-range level: output on at or above the level
   rot_on_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R7 R9
      (level_in >= LEVEL_MIN && level_in <= LEVEL_MAX && speed_in >= {2'h0, level_in})
      |=> pins_out.rotation_detect_output)
      else $error("rotation output off at or above level");

   // In-range level: output off below the level
   rot_off_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R7
      (level_in >= LEVEL_MIN && level_in <= LEVEL_MAX && speed_in < {2'h0, level_in})
      |=> !pins_out.rotation_detect_output)
      else $error("rotation output on below level");

   // Any legal level is reached by the top speed setting
   rot_level_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R7 R8
      (speed_in >= {2'h0, LEVEL_MAX}) |=> pins_out.rotation_detect_output)
      else $error("rotation output off above top level");

   // Standstill never counts as rotating
   rot_low_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R8
      (speed_in == 16'h0000) |=> !pins_out.rotation_detect_output)
      else $error("rotation output on at standstill");

   // A level below the span acts as the bottom level
   rot_floor_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R8
      (level_in < LEVEL_MIN && speed_in >= {2'h0, LEVEL_MIN})
      |=> pins_out.rotation_detect_output)
      else $error("rotation output off with low level");

   // A level above the span acts as the top level
   rot_ceil_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R8
      (level_in > LEVEL_MAX && speed_in < {2'h0, LEVEL_MAX})
      |=> !pins_out.rotation_detect_output)
      else $error("rotation output on with high level");

   // Power-on command is noted on the next cycle
   sens_set_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R2
      cmd_in.encoder_power_on_cmd |=> offset_on_out)
      else $error("power-on command not taken");

   // Power-on stays noted until reset
   sens_keep_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R2
      offset_on_out |=> offset_on_out)
      else $error("power-on state lost");

   // No offset is in effect before power-on
   offset_gate_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R2
      !offset_on_out |-> st_q.offset_eff == OFFSET_RESET)
      else $error("offset applied before power-on");

   // Before power-on the machine position is the raw encoder position
   pos_plain_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R2
      !offset_on_out |=> mach_pos_out == $past(enc_pos_in))
      else $error("machine position shifted before power-on");

   // Effective offset never leaves the legal span
   offset_range_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R3
      st_q.offset_eff <= OFFSET_MAX && st_q.offset_eff >= OFFSET_MIN)
      else $error("offset out of range");

   // An in-range setting is taken as it stands
   offset_apply_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R3
      (offset_on_out || cmd_in.encoder_power_on_cmd) && offset_in <= OFFSET_MAX
      && offset_in >= OFFSET_MIN |=> st_q.offset_eff == $past(offset_in))
      else $error("offset setting not applied");

   // A setting above the span saturates at the top
   offset_sat_hi_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R3
      (offset_on_out || cmd_in.encoder_power_on_cmd) && offset_in > OFFSET_MAX
      |=> st_q.offset_eff == OFFSET_MAX)
      else $error("offset not saturated high");

   // A setting below the span saturates at the bottom
   offset_sat_lo_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R3
      (offset_on_out || cmd_in.encoder_power_on_cmd) && offset_in < OFFSET_MIN
      |=> st_q.offset_eff == OFFSET_MIN)
      else $error("offset not saturated low");

   // A steady setting is in effect one cycle after it is seen
   offset_track_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R3
      offset_on_out ##1 $stable(offset_in) |-> st_q.offset_eff == offset_c)
      else $error("offset did not apply immediately");
endmodule // servo_status_outputs

// *** hdl/status_out_pkg.sv ***
// Constants and carrier types for the servo status-output block.
// Assumes a single 125 MHz clock and a synchronous active-low reset.
// Contract
// R1 - Machine position is encoder position minus offset
// R2 - Offset applies only after encoder power-on command
// R3 - Offset signed, +-1073741823, default 0, immediate
// R4 - Fault output closed normally, open on error
// R5 - Fault-clear command clears latched fault
// R6 - Warning output closed while warning present
// R7 - Rotation output closed when speed at/above level
// R8 - Rotation level 1..10000 rpm, default 20, immediate
// R9 - Conditions evaluated each cycle, outputs next cycle
package status_out_pkg;
   // =====================================================
   // Setting limits and reset values
   // =====================================================
   localparam logic signed [31:0] OFFSET_MAX   = 32'sh3fffffff;
   localparam logic signed [31:0] OFFSET_MIN   = -32'sh3fffffff;
   localparam logic signed [31:0] OFFSET_RESET = 32'sh00000000;
   localparam logic [13:0]        LEVEL_MIN    = 14'h0001;
   localparam logic [13:0]        LEVEL_MAX    = 14'h2710;
   localparam logic [13:0]        LEVEL_RESET  = 14'h0014;

   // =====================================================
   // Carriers
   // =====================================================
   typedef struct packed {
      logic encoder_power_on_cmd; // Encoder power-on command pulse
      logic fault_clear_cmd;      // Clear latched fault (alarm) pulse
   } link_cmd_t;

   typedef struct packed {
      logic fault_output;           // 1 = closed (normal)
      logic warn_output;            // 1 = closed (warning)
      logic rotation_detect_output; // 1 = closed (rotating)
   } status_pins_t;

   // Pin levels after reset: fault closed, warning and rotation open
   localparam status_pins_t PINS_RESET = 3'h4;
endpackage

// *** hdl/offset_adder.sv ***
// Registered machine-coordinate adder.
// Assumes offset already clamped and gated by the caller.
`timescale 1ns/1ps
module offset_adder
(
   input  wire logic               sys_clk_in,  // 125 MHz clock
   input  wire logic               nrst_in,     // Sync reset, active low
   input  wire logic signed [31:0] enc_pos_in,  // Encoder position
   input  wire logic signed [31:0] offset_in,   // Effective offset
   output logic signed [31:0]      mach_pos_out // Machine coordinate
);
   import status_out_pkg::*;

   typedef struct packed {
      logic signed [31:0] pos;
   } add_state_t;

   add_state_t st_q;
   add_state_t st_d;

   // =====================================================
   // Position shift
   // =====================================================
   // Encoder reading X at the origin gives offset X
   always_comb
   begin
      st_d     = st_q;
      st_d.pos = enc_pos_in - offset_in; // R1
   end

   // Register stage
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign mach_pos_out = st_q.pos;

   // Output is last cycle's encoder position minus offset, once out of reset
   shift_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // R1
      $past(nrst_in) |-> mach_pos_out == $past(enc_pos_in) - $past(offset_in))
      else $error("machine position not encoder minus offset");
endmodule // offset_adder

// *** sim/host_link_model.sv ***
// Host controller model: turns bench requests into link command pulses.
// Assumes requests come only after reset release, one cycle each.
`timescale 1ns/1ps
module host_link_model
(
   input  wire logic                 sys_clk_in, // 125 MHz clock
   input  wire logic                 nrst_in,    // Sync reset, active low
   input  wire logic                 pwr_req_in, // Send power-on
   input  wire logic                 clr_req_in, // Send fault clear
   output status_out_pkg::link_cmd_t cmd_out     // Command pulses
);
   import status_out_pkg::*;
   // Each request leaves as a one-cycle command on the next edge
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
         cmd_out <= '0;
      else
      begin
         cmd_out.encoder_power_on_cmd <= pwr_req_in;
         cmd_out.fault_clear_cmd      <= clr_req_in;
      end
   end
endmodule // host_link_model

// *** sim/servo_status_outputs_test.sv ***
// Self-checking bench for the status-output block.
// Assumes the host model drives the link; speed and settings from here.
`timescale 1ns/1ps
module servo_status_outputs_test;
   import status_out_pkg::*;
   logic clk = 0, nrst = 0, pwr = 0, clr = 0, flt = 0, wrn = 0;
   logic [15:0]        spd = '0;
   logic [13:0]        lvl = LEVEL_RESET;
   logic signed [31:0] ofs = '0, enc = '0, pos;
   link_cmd_t          cmd;
   status_pins_t       pins;
   logic               on;
   int                 error_cnt = 0, n_tests = 0;
   host_link_model i_host (.sys_clk_in(clk), .nrst_in(nrst), .pwr_req_in(pwr),
      .clr_req_in(clr), .cmd_out(cmd));
   servo_status_outputs i_dut (.sys_clk_in(clk), .nrst_in(nrst), .cmd_in(cmd),
      .fault_cond_in(flt), .warn_cond_in(wrn), .speed_in(spd), .level_in(lvl),
      .offset_in(ofs), .enc_pos_in(enc), .pins_out(pins), .offset_on_out(on),
      .mach_pos_out(pos));
   // Clock at 8 ns
   initial
   begin
      forever #4 clk = ~clk;
   end
   // =====================================================
   // Helpers
   // =====================================================
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (e !== g)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One request cycle to the host model: 1 = fault clear, 0 = power-on
   task automatic send(input logic clr_sel);
      @(posedge clk);
      if (clr_sel)
         clr <= 1'b1;
      else
         pwr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      pwr <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // =====================================================
   // Scenarios
   // =====================================================
   task automatic t_offset();
      @(posedge clk);
      ofs <= 32'sd5;
      enc <= 32'sd100;
      tick(3);
      chk("pos before power-on", 32'sd100, pos);
      send(1'b0);
      tick(3);
      chk("offset on", 1, on);
      chk("pos shifted", 32'sd95, pos);
      @(posedge clk) ofs <= -32'sd7;
      tick(2);
      chk("pos new offset", 32'sd107, pos);
      @(posedge clk) ofs <= 32'sh40000000;
      tick(2);
      chk("pos clamped", 32'sd100 - OFFSET_MAX, pos);
      @(posedge clk) ofs <= -32'sh40000000;
      tick(2);
      chk("pos clamped low", 32'sd100 - OFFSET_MIN, pos);
   endtask
   task automatic t_fault();
      @(posedge clk) flt <= 1'b1;
      tick(1);
      chk("fault open", 0, pins.fault_output);
      send(1'b1);
      tick(3);
      chk("clear refused", 0, pins.fault_output);
      @(posedge clk) flt <= 1'b0;
      tick(3);
      chk("fault latched", 0, pins.fault_output);
      send(1'b1);
      tick(3);
      chk("fault cleared", 1, pins.fault_output);
   endtask
   task automatic t_warn();
      @(posedge clk) wrn <= 1'b1;
      tick(1);
      chk("warn on", 1, pins.warn_output);
      @(posedge clk) wrn <= 1'b0;
      tick(1);
      chk("warn off", 0, pins.warn_output);
   endtask
   task automatic t_rot(input logic [13:0] l, input logic [15:0] s, input logic e);
      @(posedge clk);
      lvl <= l;
      spd <= s;
      tick(1);
      chk("rotation", e, pins.rotation_detect_output);
   endtask
   // Mid-run reset drops power-on state; a new command restores the offset
   task automatic t_reset();
      @(posedge clk) nrst <= 1'b0;
      tick(2);
      chk("mid reset rotation", 1'h0, pins.rotation_detect_output);
      chk("mid reset offset on", 1'h0, on);
      chk("mid reset pos", 32'sh0, pos);
      @(posedge clk) nrst <= 1'b1;
      tick(3);
      chk("offset off after reset", 1'h0, on);
      chk("pos after reset", 32'sh64, pos);
      send(1'b0);
      tick(3);
      chk("pos offset back", 32'sh64 - OFFSET_MIN, pos);
   endtask
   // Main sequence
   initial
   begin
      tick(8);
      chk("reset fault", 1, pins.fault_output);
      chk("reset warn", 0, pins.warn_output);
      chk("reset offset on", 0, on);
      @(posedge clk) nrst <= 1'b1;
      t_offset();
      t_fault();
      t_warn();
      t_rot(14'd20, 16'd19, 0);
      t_rot(14'd20, 16'd20, 1);
      t_rot(14'd0, 16'd1, 1);
      t_rot(14'd0, 16'd0, 0);
      t_rot(14'd10001, 16'd9999, 0);
      t_rot(14'd10001, 16'd10000, 1);
      t_reset();
      wrap_up();
   end
   // Hang guard
   initial
   begin
      #400000;
      error_cnt++;
      wrap_up();
   end
endmodule // servo_status_outputs_test
